// ---- tb/signal_modulator_tb.sv ----
// Self-checking bench of the signal modulator: table of mixes, then hand cases.
// Assumes the design package and source_model are compiled first.
module signal_modulator_tb;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
  typedef struct packed {logic [7:0] c; logic [3:0] m, h, l; logic [13:0] s; logic e;} row_t;
  logic        ref_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, out, ref_out, run_ref = 1'b0;
  logic [13:0] src = 14'h0;
  logic [3:0]  pwm;
  logic [9:0]  misc;
  int          mismatches = 0, compares = 0, n;
  row_t        rows[17] = '{
    '{8'hC0, 4'h2, 4'h2, 4'h0, 14'h1001, 1'b1}, '{8'hC0, 4'h2, 4'h2, 4'h3, 14'h2000, 1'b1},
    '{8'hC0, 4'h9, 4'h2, 4'h0, 14'h1010, 1'b0}, '{8'hC0, 4'h9, 4'h2, 4'h0, 14'h1050, 1'b1},
    '{8'hC0, 4'hA, 4'h2, 4'h0, 14'h10A0, 1'b1}, '{8'hC0, 4'h6, 4'h7, 4'h0, 14'h0108, 1'b1},
    '{8'hC0, 4'h7, 4'h0, 4'h6, 14'h0004, 1'b1}, '{8'hC0, 4'h8, 4'h5, 4'h0, 14'h0402, 1'b1},
    '{8'hC0, 4'h1, 4'h6, 4'h0, 14'h0804, 1'b1}, '{8'hC1, 4'h0, 4'h4, 4'h0, 14'h0001, 1'b1},
    '{8'hC0, 4'hF, 4'h2, 4'hF, 14'h3000, 1'b0}, '{8'h80, 4'h2, 4'h2, 4'h0, 14'h1001, 1'b0},
    '{8'hC0, 4'h3, 4'h7, 4'h0, 14'h000A, 1'b1}, '{8'hC0, 4'h5, 4'h6, 4'h0, 14'h000C, 1'b1},
    '{8'hC0, 4'h4, 4'h0, 4'h7, 14'h0008, 1'b1}, '{8'hC1, 4'h0, 4'h1, 4'h0, 14'h0000, 1'b0},
    '{8'h41, 4'h2, 4'h2, 4'h2, 14'h1000, 1'b0}};
  signal_modulator signal_modulator_i (.ref_clk(ref_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capture_pwm_in(pwm), .serial_data_out_a(misc[0]),
    .serial_data_out_b(misc[1]), .spi_mode_a(misc[2]), .spi_mode_b(misc[3]),
    .comparator_one(misc[4]), .comparator_two(misc[5]), .async_serial_tx(misc[6]),
    .ref_clock_out(ref_out), .external_modulator_pin(misc[7]),
    .external_carrier_pin_a(misc[8]), .external_carrier_pin_b(misc[9]),
    .modulated_output_pin(out));
  source_model source_model_i (.ref_clk(ref_clk), .run_ref(run_ref), .src(src), .pwm(pwm),
    .misc(misc), .ref_out(ref_out));
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin @(posedge ref_clk); end while (pready !== 1'b1);  // Watchdog ends a hang
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic wait_n(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : wait_n
  task automatic sync_case(input logic [7:0] h, l, c0, c1, input logic [13:0] s, input logic e);
    apb(1, sigmod_pkg::CARH_OFF, {24'h0, h}); apb(1, sigmod_pkg::CARL_OFF, {24'h0, l});
    apb(1, sigmod_pkg::SRC_OFF, 32'h0); src <= s; apb(1, sigmod_pkg::CTRL_OFF, {24'h0, c0});
    wait_n(4); `CHK(out, 1'b1)
    apb(1, sigmod_pkg::CTRL_OFF, {24'h0, c1}); wait_n(5);
    `CHK(out, e)
    src <= 14'h0; wait_n(4); `CHK(out, 1'b0)
    $display("sync case done");
  endtask : sync_case
  task automatic end_of_test;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  initial begin
    wait_n(3); srst <= 1'b0; @(posedge ref_clk);
    for (n = 0; n < 4; n++) begin
      apb(0, 12'(4 * n), 32'h0); `CHK(rd, 32'h0) `CHK(err, 1'b0)
    end
    apb(0, 12'h014, 32'h0); `CHK(err, 1'b1) `CHK(rd, 32'h0) `CHK(out, 1'b0)
    $display("reset and map done");
    foreach (rows[i]) begin
      apb(1, sigmod_pkg::SRC_OFF, {28'h0, rows[i].m});
      apb(1, sigmod_pkg::CARH_OFF, {28'h0, rows[i].h});
      apb(1, sigmod_pkg::CARL_OFF, {28'h0, rows[i].l}); src <= rows[i].s;
      apb(1, sigmod_pkg::CTRL_OFF, {24'h0, rows[i].c}); wait_n(4);
      `CHK(out, rows[i].e)
      $display("row %0d done", i);
    end
    apb(0, sigmod_pkg::SRC_OFF, 32'h0); `CHK(rd[3:0], 4'h2)
    apb(0, sigmod_pkg::CARL_OFF, 32'h0); `CHK(rd[3:0], 4'h2)
    apb(1, sigmod_pkg::CTRL_OFF, 32'h000000C0); wait_n(4); `CHK(out, 1'b1)
    apb(0, sigmod_pkg::STAT_OFF, 32'h0); `CHK(rd, 32'h0000_0001)
    $display("re-enable done");
    sync_case(8'h84, 8'h00, 8'hC1, 8'hC0, 14'h0001, 1'b1);
    sync_case(8'h04, 8'h80, 8'hC1, 8'hC0, 14'h0001, 1'b0);
    sync_case(8'h00, 8'h85, 8'hC0, 8'hC1, 14'h0002, 1'b1);
    apb(1, sigmod_pkg::CARH_OFF, 32'h1); apb(1, sigmod_pkg::CTRL_OFF, 32'hC1);
    run_ref <= 1'b1; wait_n(4); n = 0;
    repeat (40) begin @(posedge ref_clk); n += int'(out === 1'b1); end
    `CHK(n, 20)
    $display("reference carrier done");
    srst <= 1'b1; wait_n(2); srst <= 1'b0; @(posedge ref_clk);
    `CHK(out, 1'b0)
    apb(0, sigmod_pkg::CTRL_OFF, 32'h0); `CHK(rd, 32'h0)
    apb(0, sigmod_pkg::CARH_OFF, 32'h0); `CHK(rd, 32'h0)
    $display("mid-run reset done");
    end_of_test();
  end
  initial begin
    wait_n(3000); mismatches++; end_of_test();
  end
endmodule : signal_modulator_tb

// ---- tb/source_model.sv ----
// Far-side sources of the modulator: peripheral levels and a divided reference clock.
// Assumes the bench changes the levels just after rising edges of ref_clk.
module source_model (
  input  wire logic        ref_clk, // Clock
  input  wire logic        run_ref, // Reference clock runs
  input  wire logic [13:0] src,     // Levels from bench
  output logic      [3:0]  pwm,     // Units a..d
  output logic      [9:0]  misc,    // Other sources
  output logic             ref_out  // Divided clock
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div_q;
  always_ff @(posedge ref_clk) begin
    div_q <= run_ref ? div_q + 2'h1 : 2'h0;
  end
  // Quarter rate, half duty; low while stopped
  assign ref_out = div_q[1];
  assign pwm     = src[3:0];
  assign misc    = src[13:4];
endmodule : source_model

// ---- verilog/pin_sync.sv ----
// Two-flop synchroniser for a group of pin inputs.
// Assumes inputs are asynchronous to ref_clk.
module pin_sync #(
  parameter int W = 3
) (
  input  wire logic         ref_clk, // Clock
  input  wire logic         srst,    // Sync reset
  input  wire logic [W-1:0] d,       // Async inputs
  output logic      [W-1:0] q        // Synchronised
);
  logic [W-1:0] meta_q;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : pin_sync

// ---- verilog/sigmod_pkg.sv ----
// Constants, register map and select codes of the signal modulator.
// Assumes an APB slave at word-aligned byte offsets, 32-bit data.
// Contract
// - Block mixes only while the module enable bit is one.
// - Enable clear forces both carriers to the ground source.
// - Enable clear takes modulator from the software modulator bit.
// - Enable clear leaves all source select fields unchanged.
// - Enable set again resumes the held source selections.
// - Output enable clear keeps mixing but blocks the pin.
// - Output enable clear holds the modulated pin low.
// - Four-bit modulator select over eleven listed sources.
// - Serial data outputs count only while their port is in SPI mode.
// - Four-bit carrier high select over eight carrier sources.
// - Separate four-bit carrier low select, same carrier sources.
// - Without sync, carriers switch at once on modulator edges.
// - With sync, running carrier pulse falls low before switching.
// - Carrier high sync bit acts independently of carrier low.
// - Carrier low sync bit acts independently of carrier high.
package sigmod_pkg;
  localparam logic [11:0] CTRL_OFF   = 12'h000;
  localparam logic [11:0] SRC_OFF    = 12'h004;
  localparam logic [11:0] CARH_OFF   = 12'h008;
  localparam logic [11:0] CARL_OFF   = 12'h00C;
  localparam logic [11:0] STAT_OFF   = 12'h010;
  localparam int          EN_POS     = 7;
  localparam int          OE_POS     = 6;
  localparam int          SWBIT_POS  = 0;
  localparam int          SYNC_POS   = 7;
  localparam logic [3:0]  SEL_RESET  = 4'h0;
  localparam logic [3:0]  MOD_SWBIT  = 4'h0;
  localparam logic [3:0]  MOD_PIN    = 4'h1;
  localparam logic [3:0]  MOD_CCPA   = 4'h2;
  localparam logic [3:0]  MOD_CCPB   = 4'h3;
  localparam logic [3:0]  MOD_CCPC   = 4'h4;
  localparam logic [3:0]  MOD_CCPD   = 4'h5;
  localparam logic [3:0]  MOD_CMP1   = 4'h6;
  localparam logic [3:0]  MOD_CMP2   = 4'h7;
  localparam logic [3:0]  MOD_TX     = 4'h8;
  localparam logic [3:0]  MOD_SDOA   = 4'h9;
  localparam logic [3:0]  MOD_SDOB   = 4'hA;
  localparam logic [3:0]  CAR_GND    = 4'h0;
  localparam logic [3:0]  CAR_REFCLK = 4'h1;
  localparam logic [3:0]  CAR_PINA   = 4'h2;
  localparam logic [3:0]  CAR_PINB   = 4'h3;
  localparam logic [3:0]  CAR_CCPA   = 4'h4;
  localparam logic [3:0]  CAR_CCPB   = 4'h5;
  localparam logic [3:0]  CAR_CCPC   = 4'h6;
  localparam logic [3:0]  CAR_CCPD   = 4'h7;
endpackage : sigmod_pkg

// ---- verilog/signal_modulator.sv ----
// Data signal modulator: APB registers, source muxes, carrier sync, mixer.
// Assumes on-chip sources are on ref_clk; the three pins are asynchronous.
//
// Local design decisions: the APB slave port and the register addresses.
module signal_modulator (
  input  wire logic        ref_clk,                // 10 MHz clock
  input  wire logic        srst,                   // Sync reset, high
  input  wire logic        psel,                   // APB select
  input  wire logic        penable,                // APB enable
  input  wire logic        pwrite,                 // APB write
  input  wire logic [11:0] paddr,                  // APB byte address
  input  wire logic [31:0] pwdata,                 // APB write data
  output logic      [31:0] prdata,                 // APB read data
  output logic             pready,                 // APB ready
  output logic             pslverr,                // APB error
  input  wire logic [3:0]  capture_pwm_in,         // Units a..d
  input  wire logic        serial_data_out_a,      // Serial port a data
  input  wire logic        serial_data_out_b,      // Serial port b data
  input  wire logic        spi_mode_a,             // Port a in SPI mode
  input  wire logic        spi_mode_b,             // Port b in SPI mode
  input  wire logic        comparator_one,         // Comparator 1 out
  input  wire logic        comparator_two,         // Comparator 2 out
  input  wire logic        async_serial_tx,        // UART transmit
  input  wire logic        ref_clock_out,          // Reference clock
  input  wire logic        external_modulator_pin, // Async pin
  input  wire logic        external_carrier_pin_a, // Async pin
  input  wire logic        external_carrier_pin_b, // Async pin
  output logic             modulated_output_pin    // Mixed output
);

  logic       module_enable_bit_q;
  logic       output_enable_bit_q;
  logic       software_modulator_bit_q;
  logic [3:0] modulator_source_select_q;
  logic [3:0] carrier_high_select_q;
  logic [3:0] carrier_low_select_q;
  logic       carrier_high_sync_enable_q;
  logic       carrier_low_sync_enable_q;
  logic [2:0] pins_s;
  logic       mod_raw;
  logic       carh_raw;
  logic       carl_raw;
  logic       mod_q;
  logic       use_high_q;
  logic       use_high_d;
  logic       mix;

  pin_sync #(.W(3)) u_sync (
    .ref_clk (ref_clk),
    .srst    (srst),
    .d       ({external_carrier_pin_b, external_carrier_pin_a, external_modulator_pin}),
    .q       (pins_s)
  );

  // Carrier mux, shared by both carrier selects
  function automatic logic car_pick(input logic [3:0] sel, input logic [3:0] ccp,
                                    input logic rclk, input logic [2:0] pins);
    case (sel)
      sigmod_pkg::CAR_REFCLK: car_pick = rclk;
      sigmod_pkg::CAR_PINA:   car_pick = pins[1];
      sigmod_pkg::CAR_PINB:   car_pick = pins[2];
      sigmod_pkg::CAR_CCPA:   car_pick = ccp[0];
      sigmod_pkg::CAR_CCPB:   car_pick = ccp[1];
      sigmod_pkg::CAR_CCPC:   car_pick = ccp[2];
      sigmod_pkg::CAR_CCPD:   car_pick = ccp[3];
      default:                car_pick = 1'b0;
    endcase
  endfunction : car_pick

  // APB register writes
  logic wr;
  assign wr = psel && penable && pwrite;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      module_enable_bit_q        <= 1'b0;
      output_enable_bit_q        <= 1'b0;
      software_modulator_bit_q   <= 1'b0;
      modulator_source_select_q  <= sigmod_pkg::SEL_RESET;
      carrier_high_select_q      <= sigmod_pkg::SEL_RESET;
      carrier_low_select_q       <= sigmod_pkg::SEL_RESET;
      carrier_high_sync_enable_q <= 1'b0;
      carrier_low_sync_enable_q  <= 1'b0;
    end else if (wr) begin
      case (paddr)
        sigmod_pkg::CTRL_OFF: begin
          module_enable_bit_q      <= pwdata[sigmod_pkg::EN_POS];
          output_enable_bit_q      <= pwdata[sigmod_pkg::OE_POS];
          software_modulator_bit_q <= pwdata[sigmod_pkg::SWBIT_POS];
        end
        sigmod_pkg::SRC_OFF:  modulator_source_select_q <= pwdata[3:0];
        sigmod_pkg::CARH_OFF: begin
          carrier_high_select_q      <= pwdata[3:0];
          carrier_high_sync_enable_q <= pwdata[sigmod_pkg::SYNC_POS];
        end
        sigmod_pkg::CARL_OFF: begin
          carrier_low_select_q      <= pwdata[3:0];
          carrier_low_sync_enable_q <= pwdata[sigmod_pkg::SYNC_POS];
        end
        default: ;
      endcase
    end
  end

  // APB read and answer, one access cycle, no wait states
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable) begin
        case (paddr)
          sigmod_pkg::CTRL_OFF: begin
            prdata[sigmod_pkg::EN_POS]    <= module_enable_bit_q;
            prdata[sigmod_pkg::OE_POS]    <= output_enable_bit_q;
            prdata[sigmod_pkg::SWBIT_POS] <= software_modulator_bit_q;
          end
          sigmod_pkg::SRC_OFF:  prdata[3:0] <= modulator_source_select_q;
          sigmod_pkg::CARH_OFF: begin
            prdata[3:0] <= carrier_high_select_q;
            prdata[sigmod_pkg::SYNC_POS] <= carrier_high_sync_enable_q;
          end
          sigmod_pkg::CARL_OFF: begin
            prdata[3:0] <= carrier_low_select_q;
            prdata[sigmod_pkg::SYNC_POS] <= carrier_low_sync_enable_q;
          end
          sigmod_pkg::STAT_OFF: prdata[2:0] <= {use_high_q, mod_q, modulated_output_pin};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Source selection; disabled forces ground carriers and software bit
  always_comb begin
    mod_raw = software_modulator_bit_q;
    if (module_enable_bit_q) begin
      case (modulator_source_select_q)
        sigmod_pkg::MOD_SWBIT: mod_raw = software_modulator_bit_q;
        sigmod_pkg::MOD_PIN:   mod_raw = pins_s[0];
        sigmod_pkg::MOD_CCPA:  mod_raw = capture_pwm_in[0];
        sigmod_pkg::MOD_CCPB:  mod_raw = capture_pwm_in[1];
        sigmod_pkg::MOD_CCPC:  mod_raw = capture_pwm_in[2];
        sigmod_pkg::MOD_CCPD:  mod_raw = capture_pwm_in[3];
        sigmod_pkg::MOD_CMP1:  mod_raw = comparator_one;
        sigmod_pkg::MOD_CMP2:  mod_raw = comparator_two;
        sigmod_pkg::MOD_TX:    mod_raw = async_serial_tx;
        sigmod_pkg::MOD_SDOA:  mod_raw = serial_data_out_a && spi_mode_a;
        sigmod_pkg::MOD_SDOB:  mod_raw = serial_data_out_b && spi_mode_b;
        default:               mod_raw = 1'b0;
      endcase
    end // else selects kept untouched
    carh_raw = module_enable_bit_q &&
               car_pick(carrier_high_select_q, capture_pwm_in, ref_clock_out, pins_s);
    carl_raw = module_enable_bit_q &&
               car_pick(carrier_low_select_q, capture_pwm_in, ref_clock_out, pins_s);
  end

  // Active carrier choice; sync waits for the running carrier to be low
  always_comb begin
    use_high_d = use_high_q;
    if (mod_raw != use_high_q) begin
      if (use_high_q) begin
        if (!carrier_high_sync_enable_q || !carh_raw) begin
          use_high_d = 1'b0;
        end
      end else begin
        if (!carrier_low_sync_enable_q || !carl_raw) begin
          use_high_d = 1'b1;
        end
      end
    end // Unsynced switches at once
  end

  assign mix = use_high_d ? carh_raw : carl_raw;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      use_high_q           <= 1'b0;
      mod_q                <= 1'b0;
      modulated_output_pin <= 1'b0;
    end else begin
      use_high_q           <= use_high_d;
      mod_q                <= mod_raw;
      modulated_output_pin <= output_enable_bit_q && mix;
    end
  end

  // Output gating and disable behaviour
  out_low_a: assert property (@(posedge ref_clk) disable iff (srst)
    !$past(output_enable_bit_q) |-> !modulated_output_pin)
    else $error("output high while output disabled");
  dis_gnd_a: assert property (@(posedge ref_clk) disable iff (srst)
    !module_enable_bit_q |-> !carh_raw && !carl_raw)
    else $error("carrier live while disabled");
  dis_out_a: assert property (@(posedge ref_clk) disable iff (srst)
    !module_enable_bit_q |=> !modulated_output_pin)
    else $error("output high while block disabled");
  dis_swbit_a: assert property (@(posedge ref_clk) disable iff (srst)
    !module_enable_bit_q |-> mod_raw == software_modulator_bit_q)
    else $error("modulator not from software bit");
  sel_keep_a: assert property (@(posedge ref_clk) disable iff (srst)
    !wr |=> $stable(modulator_source_select_q) && $stable(carrier_high_select_q)
    && $stable(carrier_low_select_q))
    else $error("select changed without write");
  mix_path_a: assert property (@(posedge ref_clk) disable iff (srst)
    output_enable_bit_q |=> modulated_output_pin == $past(mix))
    else $error("output not the mix");

  // Modulator source decode
  mod_swbit_a: assert property (@(posedge ref_clk) disable iff (srst)
    module_enable_bit_q && modulator_source_select_q == sigmod_pkg::MOD_SWBIT
    |-> mod_raw == software_modulator_bit_q)
    else $error("enabled software bit not used");
  mod_pin_a: assert property (@(posedge ref_clk) disable iff (srst)
    module_enable_bit_q && modulator_source_select_q == sigmod_pkg::MOD_PIN
    |-> mod_raw == pins_s[0])
    else $error("modulator not from pin");
  mod_pwma_a: assert property (@(posedge ref_clk) disable iff (srst)
    module_enable_bit_q && modulator_source_select_q == sigmod_pkg::MOD_CCPA
    |-> mod_raw == capture_pwm_in[0])
    else $error("modulator not from unit a");
  mod_pwmb_a: assert property (@(posedge ref_clk) disable iff (srst)
    module_enable_bit_q && modulator_source_select_q == sigmod_pkg::MOD_CCPB
    |-> mod_raw == capture_pwm_in[1])
    else $error("modulator not from unit b");
  mod_pwmc_a: assert property (@(posedge ref_clk) disable iff (srst)
    module_enable_bit_q && modulator_source_select_q == sigmod_pkg::MOD_CCPC
    |-> mod_raw == capture_pwm_in[2])
    else $error("modulator not from unit c");
  mod_pwmd_a: assert property (@(posedge ref_clk) disable iff (srst)
    module_enable_bit_q && modulator_source_select_q == sigmod_pkg::MOD_CCPD
    |-> mod_raw == capture_pwm_in[3])
    else $error("modulator not from unit d");
  mod_cmp1_a: assert property (@(posedge ref_clk) disable iff (srst)
    module_enable_bit_q && modulator_source_select_q == sigmod_pkg::MOD_CMP1
    |-> mod_raw == comparator_one)
    else $error("modulator not from comparator one");
  mod_cmp2_a: assert property (@(posedge ref_clk) disable iff (srst)
    module_enable_bit_q && modulator_source_select_q == sigmod_pkg::MOD_CMP2
    |-> mod_raw == comparator_two)
    else $error("modulator not from comparator two");
  mod_tx_a: assert property (@(posedge ref_clk) disable iff (srst)
    module_enable_bit_q && modulator_source_select_q == sigmod_pkg::MOD_TX
    |-> mod_raw == async_serial_tx)
    else $error("modulator not from transmit line");
  mod_sdoa_a: assert property (@(posedge ref_clk) disable iff (srst)
    module_enable_bit_q && modulator_source_select_q == sigmod_pkg::MOD_SDOA
    |-> mod_raw == (serial_data_out_a && spi_mode_a))
    else $error("modulator not from serial port a");
  mod_sdob_a: assert property (@(posedge ref_clk) disable iff (srst)
    module_enable_bit_q && modulator_source_select_q == sigmod_pkg::MOD_SDOB
    |-> mod_raw == (serial_data_out_b && spi_mode_b))
    else $error("modulator not from serial port b");
  spi_gate_a: assert property (@(posedge ref_clk) disable iff (srst)
    module_enable_bit_q && modulator_source_select_q == sigmod_pkg::MOD_SDOA
    && !spi_mode_a |-> !mod_raw)
    else $error("serial data used outside SPI mode");
  mod_spare_a: assert property (@(posedge ref_clk) disable iff (srst)
    module_enable_bit_q && modulator_source_select_q > sigmod_pkg::MOD_SDOB
    |-> !mod_raw)
    else $error("spare modulator code not ground");

  // Carrier source decode
  carh_ref_a: assert property (@(posedge ref_clk) disable iff (srst)
    module_enable_bit_q && carrier_high_select_q == sigmod_pkg::CAR_REFCLK
    |-> carh_raw == ref_clock_out)
    else $error("high carrier not reference clock");
  carh_pina_a: assert property (@(posedge ref_clk) disable iff (srst)
    module_enable_bit_q && carrier_high_select_q == sigmod_pkg::CAR_PINA
    |-> carh_raw == pins_s[1])
    else $error("high carrier not pin a");
  carh_pinb_a: assert property (@(posedge ref_clk) disable iff (srst)
    module_enable_bit_q && carrier_high_select_q == sigmod_pkg::CAR_PINB
    |-> carh_raw == pins_s[2])
    else $error("high carrier not pin b");
  carh_pwma_a: assert property (@(posedge ref_clk) disable iff (srst)
    module_enable_bit_q && carrier_high_select_q == sigmod_pkg::CAR_CCPA
    |-> carh_raw == capture_pwm_in[0])
    else $error("high carrier not unit a");
  carh_pwmb_a: assert property (@(posedge ref_clk) disable iff (srst)
    module_enable_bit_q && carrier_high_select_q == sigmod_pkg::CAR_CCPB
    |-> carh_raw == capture_pwm_in[1])
    else $error("high carrier not unit b");
  carh_pwmc_a: assert property (@(posedge ref_clk) disable iff (srst)
    module_enable_bit_q && carrier_high_select_q == sigmod_pkg::CAR_CCPC
    |-> carh_raw == capture_pwm_in[2])
    else $error("high carrier not unit c");
  carh_pwmd_a: assert property (@(posedge ref_clk) disable iff (srst)
    module_enable_bit_q && carrier_high_select_q == sigmod_pkg::CAR_CCPD
    |-> carh_raw == capture_pwm_in[3])
    else $error("high carrier not unit d");
  carh_spare_a: assert property (@(posedge ref_clk) disable iff (srst)
    carrier_high_select_q > sigmod_pkg::CAR_CCPD |-> !carh_raw)
    else $error("spare high carrier code not ground");
  carl_pina_a: assert property (@(posedge ref_clk) disable iff (srst)
    module_enable_bit_q && carrier_low_select_q == sigmod_pkg::CAR_PINA
    |-> carl_raw == pins_s[1])
    else $error("low carrier not pin a");
  carl_pinb_a: assert property (@(posedge ref_clk) disable iff (srst)
    module_enable_bit_q && carrier_low_select_q == sigmod_pkg::CAR_PINB
    |-> carl_raw == pins_s[2])
    else $error("low carrier not pin b");
  carl_pwmb_a: assert property (@(posedge ref_clk) disable iff (srst)
    module_enable_bit_q && carrier_low_select_q == sigmod_pkg::CAR_CCPB
    |-> carl_raw == capture_pwm_in[1])
    else $error("low carrier not unit b");
  carl_pwmc_a: assert property (@(posedge ref_clk) disable iff (srst)
    module_enable_bit_q && carrier_low_select_q == sigmod_pkg::CAR_CCPC
    |-> carl_raw == capture_pwm_in[2])
    else $error("low carrier not unit c");
  carl_spare_a: assert property (@(posedge ref_clk) disable iff (srst)
    carrier_low_select_q > sigmod_pkg::CAR_CCPD |-> !carl_raw)
    else $error("spare low carrier code not ground");

  // Carrier switching
  nosync_hi_a: assert property (@(posedge ref_clk) disable iff (srst)
    !carrier_low_sync_enable_q && mod_raw && !use_high_q |=> use_high_q)
    else $error("unsynced switch to high late");
  nosync_lo_a: assert property (@(posedge ref_clk) disable iff (srst)
    !carrier_high_sync_enable_q && !mod_raw && use_high_q |=> !use_high_q)
    else $error("unsynced switch to low late");
  sync_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
    carrier_high_sync_enable_q && use_high_q && carh_raw |=> use_high_q)
    else $error("high carrier cut while pulse high");
  sync_lo_a: assert property (@(posedge ref_clk) disable iff (srst)
    carrier_low_sync_enable_q && !use_high_q && carl_raw |=> !use_high_q)
    else $error("low carrier cut while pulse high");

  // Register bus answer
  rdy_access_a: assert property (@(posedge ref_clk) disable iff (srst)
    psel && penable |-> pready)
    else $error("access phase without ready");
  err_ready_a: assert property (@(posedge ref_clk) disable iff (srst)
    pslverr |-> pready)
    else $error("error without ready");
  rd_idle_a: assert property (@(posedge ref_clk) disable iff (srst)
    !pready |-> prdata == 32'h0000_0000)
    else $error("read data outside answer");
  wr_ctrl_a: assert property (@(posedge ref_clk) disable iff (srst)
    wr && paddr == sigmod_pkg::CTRL_OFF
    |=> module_enable_bit_q == $past(pwdata[sigmod_pkg::EN_POS]))
    else $error("enable write lost");
  wr_carh_a: assert property (@(posedge ref_clk) disable iff (srst)
    wr && paddr == sigmod_pkg::CARH_OFF |=> carrier_high_select_q == $past(pwdata[3:0]))
    else $error("high carrier select write lost");

endmodule : signal_modulator
